/* File: logic/irq_prio_pkg.sv */
/*
 * shared constants and carrier types for the interrupt priority bank:
 * register offsets, field positions, reset value, bus response codes.
 * assumes a 32-bit axi4-lite register bus and 16-bit registers.
 */
package irq_prio_pkg;

    // byte offsets of the four priority registers
    localparam logic [7:0] OFF_GROUP_A = 8'h00;
    localparam logic [7:0] OFF_GROUP_B = 8'h04;
    localparam logic [7:0] OFF_GROUP_C = 8'h08;
    localparam logic [7:0] OFF_GROUP_D = 8'h0C;
    localparam int ADDR_W = 8;
    localparam int NUM_REGS = 4;
    localparam int FIELDS_PER_REG = 4;

    // field low-bit positions inside a 16-bit register
    localparam int FIELD_LSB_3 = 12;
    localparam int FIELD_LSB_2 = 8;
    localparam int FIELD_LSB_1 = 4;
    localparam int FIELD_LSB_0 = 0;
    localparam int PRIO_W = 3;

    // level-4 value loaded at reset
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_DISABLED = 3'h0;

    // implemented-bit masks per register
    localparam logic [15:0] MASK_A = 16'h7777;
    localparam logic [15:0] MASK_B = 16'h0007;
    localparam logic [15:0] MASK_C = 16'h7777;
    localparam logic [15:0] MASK_D = 16'h7777;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one decoded priority: level and enable travel together
    typedef struct packed {
        logic enabled;
        logic [2:0] level;
    } prio_s;

endpackage : irq_prio_pkg

/* File: logic/interrupt_priority_config_regs.sv */
/*
 * interrupt priority register bank behind an axi4-lite slave.
 * four 16-bit registers of 3-bit priority fields; each field is
 * exported as a level and an enable flag to the arbiter.
 * assumes one clock, synchronous active-high reset, well-behaved master.
 */
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_config_regs #(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // read address
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // decoded priorities, index order: a3..a0, b0, c3..c0, d3..d0
    output irq_prio_pkg::prio_s change_notify_priority_out,
    output irq_prio_pkg::prio_s analog_comparator1_priority_out,
    output irq_prio_pkg::prio_s twowire1_master_priority_out,
    output irq_prio_pkg::prio_s twowire1_slave_priority_out,
    output irq_prio_pkg::prio_s external_irq1_priority_out,
    output irq_prio_pkg::prio_s timer_four_priority_out,
    output irq_prio_pkg::prio_s out_compare_ch4_priority_out,
    output irq_prio_pkg::prio_s out_compare_ch3_priority_out,
    output irq_prio_pkg::prio_s dma_ch2_done_priority_out,
    output irq_prio_pkg::prio_s serial2_transmit_priority_out,
    output irq_prio_pkg::prio_s serial2_receive_priority_out,
    output irq_prio_pkg::prio_s external_irq2_priority_out,
    output irq_prio_pkg::prio_s timer_five_priority_out
);

    // only a 32-bit bus is served
    if (DATA_W != 32)
    begin : g_bad_width
        $error("DATA_W must be 32");
    end

    // ports are cut for an 8-bit byte address
    if (irq_prio_pkg::ADDR_W != 8)
    begin : g_bad_addr
        $error("ADDR_W must be 8");
    end

    // the address decode below knows exactly four registers
    if (irq_prio_pkg::NUM_REGS != 4)
    begin : g_bad_regs
        $error("NUM_REGS must be 4");
    end

    // four fields plus a spare bit each must fit a 16-bit register
    if (irq_prio_pkg::FIELDS_PER_REG * (irq_prio_pkg::PRIO_W + 1) > 16)
    begin : g_bad_fields
        $error("priority fields overflow a register");
    end

    // one decoded output per implemented field
    localparam int NUM_SRC = 13;

    ////////////////////////////////////////////////////////////////////
    // write channel capture: address and data taken in either order
    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;

    // refuse both halves while a response waits or reset is held;
    // keeps one write in flight without a separate busy flag
    assign s_axi_awready_out = !aw_held_ff && !bvalid_ff && !srst_in
                               ? 1'b1 : 1'b0;
    assign s_axi_wready_out = !w_held_ff && !bvalid_ff && !srst_in
                              ? 1'b1 : 1'b0;

    // hold each half until the other arrives
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end
        else if (do_write)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata_in;
                w_strb_ff <= s_axi_wstrb_in;
            end
        end
    end

    // a write fires once both halves are present, held or arriving
    // a held half wins over the live bus, so a late half meets the first
    always_comb
    begin
        wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr_in;
        wr_data = w_held_ff ? w_data_ff : s_axi_wdata_in;
        wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb_in;
        do_write = (aw_held_ff || (s_axi_awvalid_in && s_axi_awready_out))
                   && (w_held_ff || (s_axi_wvalid_in && s_axi_wready_out));
        wr_hit = (wr_addr == irq_prio_pkg::OFF_GROUP_A)
                 || (wr_addr == irq_prio_pkg::OFF_GROUP_B)
                 || (wr_addr == irq_prio_pkg::OFF_GROUP_C)
                 || (wr_addr == irq_prio_pkg::OFF_GROUP_D);
    end

    // response stands until the master takes it
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= irq_prio_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? irq_prio_pkg::RESP_OKAY
                               : irq_prio_pkg::RESP_SLVERR;
        end
        // released only once the master has seen it
        else if (s_axi_bready_in)
        begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;

    ////////////////////////////////////////////////////////////////////
    // register storage, only implemented bits kept
    logic [15:0] regs_ff [irq_prio_pkg::NUM_REGS];
    logic [15:0] reg_mask [irq_prio_pkg::NUM_REGS];
    logic [15:0] wr_bytemask;
    logic [7:0] reg_off [irq_prio_pkg::NUM_REGS];

    // byte address each register answers to
    assign reg_off[0] = irq_prio_pkg::OFF_GROUP_A;
    assign reg_off[1] = irq_prio_pkg::OFF_GROUP_B;
    assign reg_off[2] = irq_prio_pkg::OFF_GROUP_C;
    assign reg_off[3] = irq_prio_pkg::OFF_GROUP_D;
    // implemented bits of each register
    assign reg_mask[0] = irq_prio_pkg::MASK_A;
    assign reg_mask[1] = irq_prio_pkg::MASK_B;
    assign reg_mask[2] = irq_prio_pkg::MASK_C;
    assign reg_mask[3] = irq_prio_pkg::MASK_D;
    // upper strobes land on bits above 15, which are not stored
    assign wr_bytemask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    for (genvar r = 0; r < irq_prio_pkg::NUM_REGS; r++)
    begin : g_reg
        logic [15:0] reset_val;
        logic [7:0] my_off;
        assign reset_val = reg_mask[r] & {4{1'b0, irq_prio_pkg::PRIO_RESET}};
        assign my_off = reg_off[r];
        always_ff @(posedge ref_clk_in)
        begin
            if (srst_in)
            begin
                regs_ff[r] <= reset_val;
            end
            else if (do_write && wr_addr == my_off)
            begin
                regs_ff[r] <= (regs_ff[r] & ~(wr_bytemask & reg_mask[r]))
                    | (wr_data[15:0] & wr_bytemask & reg_mask[r]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel: one read at a time, data registered
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rd_word;
    logic rd_hit;

    // a new read waits until the last one's data has been taken
    assign s_axi_arready_out = !rvalid_ff && !srst_in ? 1'b1 : 1'b0;

    // unassigned bits and the upper half read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr_in)
            irq_prio_pkg::OFF_GROUP_A: rd_word = {16'h0000, regs_ff[0]};
            irq_prio_pkg::OFF_GROUP_B: rd_word = {16'h0000, regs_ff[1]};
            irq_prio_pkg::OFF_GROUP_C: rd_word = {16'h0000, regs_ff[2]};
            irq_prio_pkg::OFF_GROUP_D: rd_word = {16'h0000, regs_ff[3]};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= irq_prio_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? irq_prio_pkg::RESP_OKAY
                               : irq_prio_pkg::RESP_SLVERR;
        end
        // released only once the master has seen it
        else if (s_axi_rready_in)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign s_axi_rresp_out = rresp_ff;

    ////////////////////////////////////////////////////////////////////
    // decoded priorities: registered one cycle after storage
    function automatic irq_prio_pkg::prio_s decode(input logic [2:0] f);
        irq_prio_pkg::prio_s p;
        p.level = f;
        p.enabled = (f != irq_prio_pkg::PRIO_DISABLED);
        return p;
    endfunction : decode

    // registered so each output leaves a flop, at one cycle of lag
    irq_prio_pkg::prio_s prio_ff [NUM_SRC];
    irq_prio_pkg::prio_s nxt_prio [NUM_SRC];

    always_comb
    begin
        nxt_prio[0] = decode(regs_ff[0][irq_prio_pkg::FIELD_LSB_3 +: 3]);
        nxt_prio[1] = decode(regs_ff[0][irq_prio_pkg::FIELD_LSB_2 +: 3]);
        nxt_prio[2] = decode(regs_ff[0][irq_prio_pkg::FIELD_LSB_1 +: 3]);
        nxt_prio[3] = decode(regs_ff[0][irq_prio_pkg::FIELD_LSB_0 +: 3]);
        nxt_prio[4] = decode(regs_ff[1][irq_prio_pkg::FIELD_LSB_0 +: 3]);
        nxt_prio[5] = decode(regs_ff[2][irq_prio_pkg::FIELD_LSB_3 +: 3]);
        nxt_prio[6] = decode(regs_ff[2][irq_prio_pkg::FIELD_LSB_2 +: 3]);
        nxt_prio[7] = decode(regs_ff[2][irq_prio_pkg::FIELD_LSB_1 +: 3]);
        nxt_prio[8] = decode(regs_ff[2][irq_prio_pkg::FIELD_LSB_0 +: 3]);
        nxt_prio[9] = decode(regs_ff[3][irq_prio_pkg::FIELD_LSB_3 +: 3]);
        nxt_prio[10] = decode(regs_ff[3][irq_prio_pkg::FIELD_LSB_2 +: 3]);
        nxt_prio[11] = decode(regs_ff[3][irq_prio_pkg::FIELD_LSB_1 +: 3]);
        nxt_prio[12] = decode(regs_ff[3][irq_prio_pkg::FIELD_LSB_0 +: 3]);
    end

    // reset mirrors the level-4 storage reset
    always_ff @(posedge ref_clk_in)
    begin
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (srst_in)
            begin
                prio_ff[i] <= '{enabled: 1'b1,
                                level: irq_prio_pkg::PRIO_RESET};
            end
            else
            begin
                prio_ff[i] <= nxt_prio[i];
            end
        end
    end

    assign change_notify_priority_out = prio_ff[0];
    assign analog_comparator1_priority_out = prio_ff[1];
    assign twowire1_master_priority_out = prio_ff[2];
    assign twowire1_slave_priority_out = prio_ff[3];
    assign external_irq1_priority_out = prio_ff[4];
    assign timer_four_priority_out = prio_ff[5];
    assign out_compare_ch4_priority_out = prio_ff[6];
    assign out_compare_ch3_priority_out = prio_ff[7];
    assign dma_ch2_done_priority_out = prio_ff[8];
    assign serial2_transmit_priority_out = prio_ff[9];
    assign serial2_receive_priority_out = prio_ff[10];
    assign external_irq2_priority_out = prio_ff[11];
    assign timer_five_priority_out = prio_ff[12];

endmodule : interrupt_priority_config_regs

`default_nettype wire

/* File: dv/irq_prio_assertions.sv */
/* concurrent checks on the priority bank's bus and priority outputs.
   assumes one clock domain and the top module's own port names. */
`timescale 1ns/1ps
`default_nettype none
module irq_prio_assertions (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire irq_prio_pkg::prio_s change_notify_priority_out,
    input wire irq_prio_pkg::prio_s external_irq1_priority_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    ////////////////////////////////////////////////////////////////////
    // both write halves taken at one edge
    sequence wr_taken;
        s_axi_awvalid_in && s_axi_awready_out &&
            s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence rd_taken;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    ////////////////////////////////////////////////////////////////////
    chk_wr_answer: assert property (
        wr_taken |=> s_axi_bvalid_out)
        else $error("write response missing");
    chk_rd_answer: assert property (
        rd_taken |=> s_axi_rvalid_out)
        else $error("read response missing");
    chk_bresp_held: assert property (
        s_axi_bvalid_out && !s_axi_bready_in
            |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped early");
    chk_rdata_held: assert property (
        s_axi_rvalid_out && !s_axi_rready_in
            |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped early");
    chk_unused_zero: assert property (
        s_axi_rvalid_out |-> (s_axi_rdata_out & ~32'h00007777) == 32'h0)
        else $error("unassigned bit read as one");
    chk_zero_disables: assert property (
        change_notify_priority_out.enabled ==
            (change_notify_priority_out.level != 3'h0))
        else $error("enable flag disagrees with level");
    chk_level_update: assert property (
        wr_taken ##0 (s_axi_awaddr_in == 8'h04 && s_axi_wstrb_in[0])
            |-> ##2 external_irq1_priority_out.level ==
                $past(s_axi_wdata_in[2:0], 2))
        else $error("field level not taken from write");
    chk_bad_addr: assert property (
        wr_taken ##0 (s_axi_awaddr_in > 8'h0C)
            |=> s_axi_bresp_out == irq_prio_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    chk_bad_keep: assert property (
        wr_taken ##0 (s_axi_awaddr_in > 8'h0C)
            |-> ##2 $stable(change_notify_priority_out))
        else $error("unmapped write changed a priority");
    chk_reset_level: assert property (
        $fell(srst_in) |-> change_notify_priority_out == 4'hC &&
            external_irq1_priority_out == 4'hC)
        else $error("priority not level four after reset");
endmodule : irq_prio_assertions
bind interrupt_priority_config_regs irq_prio_assertions u_chk (.*);
`default_nettype wire

/* File: dv/interrupt_priority_config_regs_tb.sv */
/* self-checking bench for the priority bank over axi4-lite.
   assumes the checker is bound to the design; 125 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_config_regs_tb;
logic ref_clk_in = 1'b0;
logic srst_in = 1'b1;
logic [7:0] awaddr = 8'h00, araddr = 8'h00;
logic [31:0] wdata = 32'h0;
logic [3:0] wstrb = 4'hF;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
logic arvalid = 1'b0, rready = 1'b0;
logic awready, wready, bvalid, arready, rvalid;
logic [1:0] bresp, rresp;
logic [31:0] rdata;
irq_prio_pkg::prio_s p [13];
logic [15:0] mask [4] = '{irq_prio_pkg::MASK_A, irq_prio_pkg::MASK_B,
    irq_prio_pkg::MASK_C, irq_prio_pkg::MASK_D};
int err_count = 0;
int total_checks = 0;
////////////////////////////////////////////////////////////////////////
interrupt_priority_config_regs u_dut (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready),
    .change_notify_priority_out(p[0]),
    .analog_comparator1_priority_out(p[1]),
    .twowire1_master_priority_out(p[2]),
    .twowire1_slave_priority_out(p[3]),
    .external_irq1_priority_out(p[4]),
    .timer_four_priority_out(p[5]),
    .out_compare_ch4_priority_out(p[6]),
    .out_compare_ch3_priority_out(p[7]),
    .dma_ch2_done_priority_out(p[8]),
    .serial2_transmit_priority_out(p[9]),
    .serial2_receive_priority_out(p[10]),
    .external_irq2_priority_out(p[11]),
    .timer_five_priority_out(p[12]));
always #4 ref_clk_in = ~ref_clk_in;
////////////////////////////////////////////////////////////////////////
// compare, count, report at once
task automatic chk_val(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
        err_count++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
    end
endtask : chk_val
// write with both halves offered together; dl stalls the response
task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input int dl, output logic [1:0] r);
    int n = 0;
    @(posedge ref_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (dl == 0);
    forever
    begin
        @(posedge ref_clk_in);
        n++;
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid && bready)
        begin
            r = bresp;
            bready <= 1'b0;
            break;
        end
        if (n == dl) bready <= 1'b1;
    end
endtask : wr
// read; dl holds rready low a few cycles to stall the answer
task automatic rd(input logic [7:0] a, input int dl,
    output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge ref_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (dl == 0);
    forever
    begin
        @(posedge ref_clk_in);
        n++;
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid && rready)
        begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
        end
        if (n == dl) rready <= 1'b1;
    end
endtask : rd
task automatic do_reset;
    @(posedge ref_clk_in);
    srst_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    srst_in <= 1'b0;
endtask : do_reset
////////////////////////////////////////////////////////////////////////
// every implemented field at level four, spare bits zero
task automatic t_reset_vals;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge ref_clk_in);
    chk_val("rst_ready", 32'h7, {29'h0, awready, wready, arready});
    for (int i = 0; i < 4; i++)
    begin
        rd(8'(4 * i), i, d, r);
        chk_val("rst_rdata", {16'h0, mask[i] & 16'h4444}, d);
        chk_val("rst_rresp", 32'h0, {30'h0, r});
    end
    for (int i = 0; i < 13; i++) chk_val("rst_prio", 32'hC, 32'(p[i]));
endtask : t_reset_vals
// every level 0 to 7 across the fields; upper bits of d written as ones, and every spare bit of the last register
task automatic t_fields;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] wv [4] = '{16'h1234, 16'hFFF5, 16'h5670, 16'hF9EB};
    logic [2:0] lv [13] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6,
        3'h7, 3'h0, 3'h7, 3'h1, 3'h6, 3'h3};
    for (int i = 0; i < 4; i++)
    begin
        wr(8'(4 * i), {16'hFFFF, wv[i]}, i, r);
        chk_val("wr_bresp", 32'h0, {30'h0, r});
    end
    repeat (3) @(posedge ref_clk_in);
    for (int i = 0; i < 13; i++)
        chk_val("fld_prio", {28'h0, lv[i] != 3'h0, lv[i]}, 32'(p[i]));
    for (int i = 0; i < 4; i++)
    begin
        rd(8'(4 * i), 0, d, r);
        chk_val("fld_rdata", {16'h0, wv[i] & mask[i]}, d);
    end
endtask : t_fields
// refused address leaves stored fields alone
task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h10, 32'hFFFFFFFF, 0, r);
    chk_val("bad_bresp", 32'(irq_prio_pkg::RESP_SLVERR), 32'(r));
    rd(8'h10, 0, d, r);
    chk_val("bad_rdata", 32'h0, d);
    chk_val("bad_rresp", 32'(irq_prio_pkg::RESP_SLVERR), 32'(r));
    rd(8'h00, 0, d, r);
    chk_val("keep_rdata", 32'h1234, d);
    chk_val("keep_prio", 32'h9, 32'(p[0]));
endtask : t_unmapped
// byte strobes: only the enabled lane reaches the fields
task automatic t_strobe;
    logic [31:0] d;
    logic [1:0] r;
    wstrb <= 4'h1;
    wr(8'h00, 32'h0000_0000, 0, r);
    rd(8'h00, 0, d, r);
    chk_val("strb_lo", 32'h1200, d);
    wstrb <= 4'h2;
    wr(8'h00, 32'h0000_0000, 0, r);
    rd(8'h00, 0, d, r);
    chk_val("strb_hi", 32'h0000, d);
    repeat (2) @(posedge ref_clk_in);
    chk_val("off_prio", 32'h0, 32'(p[0]));
    wstrb <= 4'hF;
endtask : t_strobe
task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask : results
////////////////////////////////////////////////////////////////////////
initial
begin
    do_reset();
    t_reset_vals();
    t_fields();
    t_unmapped();
    t_strobe();
    do_reset();
    t_reset_vals();
    results();
end
// whole run needs well under a thousand cycles
initial
begin
    repeat (5000) @(posedge ref_clk_in);
    err_count++;
    results();
end
endmodule : interrupt_priority_config_regs_tb
`default_nettype wire
